// ### dpt_checker.sv
`timescale 1ns/1ps
module dpt_checker
    import dpt_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic probe_clk,
    input wire logic md_probe_out,
    input wire logic md_probe_oe_n,
    input wire logic md_dev_oe_n,
    input wire logic nrst_dev_oe_n,
    input wire logic nrst_probe_oe_n,
    input wire logic scan_select
);
    // ------
    // Frame and pulse bookkeeping
    // ------
    // Only the last 67 bits are kept: the pattern plus the tail behind it
    logic [66:0] bits_reg;
    logic [7:0] rise_reg;
    logic [7:0] dev_low_reg;
    logic [7:0] prb_low_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bits_reg <= '0;
            rise_reg <= '0;
            dev_low_reg <= '0;
            prb_low_reg <= '0;
        end else begin
            if ($fell(md_probe_oe_n)) begin
                rise_reg <= '0;
            end else if ($rose(probe_clk)) begin
                rise_reg <= rise_reg + 8'h01;
                bits_reg <= {bits_reg[65:0], md_probe_out};
            end
            dev_low_reg <= nrst_dev_oe_n ? 8'h00 : dev_low_reg + 8'h01;
            prb_low_reg <= nrst_probe_oe_n ? 8'h00 : prb_low_reg + 8'h01;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // ------
    // Link and pin checks
    // ------
    AST_CLK_LOW: assert property ($fell(probe_clk) |=> !probe_clk [*3] ##1 probe_clk)
        else $error("probe clock low phase not four cycles");
    AST_CLK_HIGH: assert property ($rose(probe_clk) && !md_probe_oe_n |=> probe_clk [*3])
        else $error("probe clock high phase too short");
    AST_DATA_STABLE: assert property (!md_probe_oe_n && probe_clk && $past(probe_clk) |-> $stable(md_probe_out))
        else $error("mode data changed while probe clock high");
    AST_HEAD_HIGH: assert property ($fell(md_probe_oe_n) |-> (md_probe_out && !md_probe_oe_n) throughout (##300 1'b1))
        else $error("switch sequence head not held high");
    AST_FRAME_CLOCKS: assert property ($rose(md_probe_oe_n) |=> rise_reg == 8'h76)
        else $error("switch sequence clock count wrong");
    AST_FRAME_PATTERN: assert property ($rose(md_probe_oe_n) |=>
        (bits_reg[66:51] == PAT_TO_SERIAL || bits_reg[66:51] == PAT_TO_SCAN) && (&bits_reg[50:0]))
        else $error("switch pattern or tail wrong");
    AST_DEV_RST_LEN: assert property ($rose(nrst_dev_oe_n) |-> dev_low_reg >= 8'(RST_PULSE_CYC))
        else $error("device reset pulse too short");
    AST_PRB_RST_LEN: assert property ($rose(nrst_probe_oe_n) |-> prb_low_reg >= 8'(RST_PULSE_CYC))
        else $error("probe reset pulse too short");
    AST_RELEASED: assert property ($rose(resetn_i) |-> nrst_dev_oe_n && md_dev_oe_n)
        else $error("device drives pins after reset");
    AST_SEL_RESET: assert property ($changed(scan_select) |-> ##[0:4] !nrst_probe_oe_n)
        else $error("select change without chip reset");
endmodule : dpt_checker

// ### dpt_device.sv
`timescale 1ns/1ps
// What this block does
// (RQ1) Reset pin driven and sensed, open drain
// (RQ2) Pin reset hits core, peripherals, not backup
// (RQ3) Any external pulse; own pulse minimum length
// (RQ4) Reset pin released, input after reset
// (RQ5) Wipe pulse erases flash to all ones
// (RQ6) Wipe pin debounced on slow tick, minimum time
// (RQ7) Wipe pin keeps wipe function at startup
// (RQ8) Wipe pin as output never wipes
// (RQ9) Security bit never blocks wipe
// (RQ10) Debug pins start in debug port use
// (RQ11) Selector swaps debug pins to general I/O
// (RQ12) Boundary scan needs select high, qualifier low
// (RQ13) Select low gives debug port variants
// (RQ14) Strap change acts only after chip reset
// (RQ15) Every reset starts scan chain variant
// (RQ16) High run, 0x79e7, high run selects serial
// (RQ17) High run, 0x3ce7, high run selects scan
// (RQ18) Trace on data-out only in serial variant
// (RQ19) Test pin picks scan test or programming
// (RQ20) Unknown pattern ignored, variant kept
// (RQ21) New variant owns pins, other goes quiet
module dpt_device
    import dpt_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    dpt_link_if.device link,
    input wire logic rst_req_i,
    input wire logic dbg_gpio_sel_i,
    input wire logic wipe_gpio_sel_i,
    input wire logic gpio_oe_i,
    input wire logic [1:0] gpio_out_i,
    input wire logic sw_out_i,
    input wire logic sw_oe_i,
    input wire logic scan_tdo_i,
    input wire logic trace_i,
    output logic core_reset_o,
    output logic periph_reset_o,
    output logic flash_wipe_o,
    output logic variant_serial_o,
    output logic boundary_scan_o,
    output logic fast_prog_o,
    output logic sw_clk_rise_o,
    output logic scan_clk_rise_o,
    output logic md_o,
    output logic tdi_o,
    output logic [3:0] gpio_in_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic clk_prev;
        logic [1:0] warm;
        logic bscan;
        logic fprog;
        logic serial;
        dpt_det_type st;
        logic [5:0] hcnt;
        logic [15:0] pat;
        logic [4:0] bcnt;
        logic [5:0] rcnt;
        logic nrst_oe_n;
        logic [10:0] div;
        logic [7:0] wcnt;
        logic wiped;
        logic wipe_gpio;
        logic dbg_gpio;
        logic core_rst;
        logic periph_rst;
        logic wipe_pulse;
        logic sw_rise;
        logic scan_rise;
        logic md;
        logic tdi;
        logic md_out;
        logic md_oe_n;
        logic tdo;
        logic [3:0] gpio_in;
    } dpt_dev_state_type;

    localparam dpt_dev_state_type DEV_RESET = '{
        s1: SY_RESET, s2: SY_RESET, clk_prev: 1'b1, warm: 2'h0, bscan: 1'b0, fprog: 1'b0,
        serial: 1'b0, st: DET_HUNT, hcnt: 6'h00, pat: 16'h0000, bcnt: 5'h00, rcnt: 6'h00,
        nrst_oe_n: 1'b1, div: 11'h000, wcnt: 8'h00, wiped: 1'b0, wipe_gpio: 1'b0,
        dbg_gpio: 1'b0, core_rst: 1'b0, periph_rst: 1'b0, wipe_pulse: 1'b0, sw_rise: 1'b0,
        scan_rise: 1'b0, md: 1'b1, tdi: 1'b0, md_out: 1'b0, md_oe_n: 1'b1, tdo: 1'b0,
        gpio_in: 4'h0
    };

    dpt_dev_state_type q;
    dpt_dev_state_type n;

    logic clk_rise;
    logic md_bit;
    logic pin_low;
    logic det_en;
    logic slow_tick;
    logic [15:0] pat_full;

    // Saturating count keeps a long idle-high run from wrapping to zero
    function automatic logic [5:0] sat_inc(input logic [5:0] v);
        sat_inc = (v == 6'h3f) ? v : v + 6'h01;
    endfunction : sat_inc

    assign clk_rise = q.s2[SY_CLK] & ~q.clk_prev;
    assign md_bit = q.s2[SY_MD];
    assign pin_low = ~q.s2[SY_NRST];
    assign det_en = ~q.bscan & ~q.dbg_gpio;
    assign slow_tick = (q.div == SLOW_DIV_LAST);
    assign pat_full = {q.pat[14:0], md_bit};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        n.s1 = {link.wipe_pin, link.port_a_qual, link.scan_select, link.test_mode,
                link.tdi, link.nrst, link.mode_data, link.probe_clk};
        n.s2 = q.s1;
        n.clk_prev = q.s2[SY_CLK];
        n.warm = (q.warm == WARM_DONE) ? q.warm : q.warm + 2'h1;
        n.sw_rise = 1'b0;
        n.scan_rise = 1'b0;
        n.wipe_pulse = 1'b0;
        n.md = md_bit;
        n.tdi = q.s2[SY_TDI];
        n.dbg_gpio = dbg_gpio_sel_i; // RQ10 RQ11
        n.wipe_gpio = wipe_gpio_sel_i; // RQ7

        // Pin level of any length reaches core and peripherals only
        n.core_rst = pin_low; // RQ1 RQ2 RQ3
        n.periph_rst = pin_low; // RQ2

        // Own reset drive, stretched to a guaranteed length
        if (rst_req_i && q.nrst_oe_n) begin
            n.nrst_oe_n = 1'b0; // RQ1 RQ3
            n.rcnt = RST_PULSE_CYC;
        end else if (!q.nrst_oe_n) begin
            n.rcnt = q.rcnt - 6'h01;
            if (q.rcnt == 6'h01) begin
                n.nrst_oe_n = 1'b1; // RQ4
            end
        end

        // Straps are taken only while a reset is in force
        if (pin_low || q.warm != WARM_DONE) begin
            n.bscan = q.s2[SY_TEST] & q.s2[SY_SEL] & ~q.s2[SY_PORTA]; // RQ12 RQ14 RQ19
            n.fprog = q.s2[SY_TEST] & ~(q.s2[SY_SEL] & ~q.s2[SY_PORTA]); // RQ19
            n.serial = 1'b0; // RQ13 RQ15
            n.st = DET_HUNT;
            n.hcnt = 6'h00;
        end else if (det_en && clk_rise) begin
            n.sw_rise = q.serial; // RQ21
            n.scan_rise = ~q.serial; // RQ21
            case (q.st)
                DET_HUNT: begin
                    if (md_bit) begin
                        n.hcnt = sat_inc(q.hcnt);
                    end else if (q.hcnt >= SEL_HIGH_CLKS) begin
                        n.pat = 16'h0000;
                        n.bcnt = 5'h01;
                        n.st = DET_PAT;
                    end else begin
                        n.hcnt = 6'h00;
                    end
                end
                DET_PAT: begin
                    n.pat = pat_full;
                    n.bcnt = q.bcnt + 5'h01;
                    n.hcnt = 6'h00;
                    if (q.bcnt == PAT_LAST_BIT) begin
                        if ((!q.serial && pat_full == PAT_TO_SERIAL) || (q.serial && pat_full == PAT_TO_SCAN)) begin
                            n.st = DET_TAIL; // RQ16 RQ17
                        end else begin
                            n.st = DET_HUNT; // RQ20
                        end
                    end
                end
                DET_TAIL: begin
                    if (!md_bit) begin
                        n.hcnt = 6'h00;
                        n.st = DET_HUNT; // RQ20
                    end else begin
                        n.hcnt = sat_inc(q.hcnt);
                        if (sat_inc(q.hcnt) >= SEL_HIGH_CLKS) begin
                            n.serial = ~q.serial; // RQ16 RQ17 RQ21
                            n.st = DET_HUNT;
                        end
                    end
                end
                default: begin
                    n.st = DET_HUNT;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Flash wipe pin
        // ------------------------------------------------------------
        // The security bit is deliberately not an input here
        n.div = slow_tick ? 11'h000 : q.div + 11'h001;
        if (q.wipe_gpio || !q.s2[SY_WIPE]) begin
            n.wcnt = 8'h00; // RQ8
            n.wiped = 1'b0;
        end else if (slow_tick && !q.wiped) begin
            n.wcnt = q.wcnt + 8'h01; // RQ6
            if (q.wcnt + 8'h01 == WIPE_TICKS) begin
                n.wipe_pulse = 1'b1; // RQ5 RQ9
                n.wiped = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Pin drive
        // ------------------------------------------------------------
        n.gpio_in = {q.s2[SY_TDI], q.s2[SY_CLK], q.s2[SY_MD], q.s2[SY_WIPE]}; // RQ11
        if (q.dbg_gpio) begin
            n.md_out = gpio_out_i[0]; // RQ11
            n.md_oe_n = ~gpio_oe_i;
            n.tdo = gpio_out_i[1];
        end else if (q.serial && !q.bscan) begin
            n.md_out = sw_out_i; // RQ21
            n.md_oe_n = ~sw_oe_i;
            n.tdo = trace_i; // RQ18
        end else begin
            n.md_out = 1'b0;
            n.md_oe_n = 1'b1; // RQ21
            n.tdo = scan_tdo_i; // RQ18
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= DEV_RESET;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.md_dev_out = q.md_out;
    assign link.md_dev_oe_n = q.md_oe_n;
    assign link.tdo = q.tdo;
    assign link.nrst_dev_oe_n = q.nrst_oe_n;
    assign core_reset_o = q.core_rst;
    assign periph_reset_o = q.periph_rst;
    assign flash_wipe_o = q.wipe_pulse;
    assign variant_serial_o = q.serial;
    assign boundary_scan_o = q.bscan;
    assign fast_prog_o = q.fprog;
    assign sw_clk_rise_o = q.sw_rise;
    assign scan_clk_rise_o = q.scan_rise;
    assign md_o = q.md;
    assign tdi_o = q.tdi;
    assign gpio_in_o = q.gpio_in;

endmodule : dpt_device

// ### dpt_link_if.sv
`timescale 1ns/1ps
interface dpt_link_if;
    logic probe_clk;
    logic md_probe_out;
    logic md_probe_oe_n;
    logic md_dev_out;
    logic md_dev_oe_n;
    logic mode_data;
    logic tdi;
    logic tdo;
    logic nrst_dev_oe_n;
    logic nrst_probe_oe_n;
    logic nrst;
    logic test_mode;
    logic scan_select;
    logic port_a_qual;
    logic wipe_pin;

    // ------------------------------------------------------------
    // Wire resolution; the line idles high through its pull-up
    // ------------------------------------------------------------
    assign mode_data = !md_probe_oe_n ? md_probe_out : (!md_dev_oe_n ? md_dev_out : 1'b1);
    assign nrst = nrst_dev_oe_n & nrst_probe_oe_n;

    modport device (
        input probe_clk, mode_data, tdi, nrst, test_mode, scan_select, port_a_qual, wipe_pin,
        output md_dev_out, md_dev_oe_n, tdo, nrst_dev_oe_n
    );

    modport probe (
        output probe_clk, md_probe_out, md_probe_oe_n, tdi, nrst_probe_oe_n,
        output test_mode, scan_select, port_a_qual, wipe_pin,
        input mode_data, tdo, nrst
    );
endinterface : dpt_link_if

// ### dpt_pkg.sv
package dpt_pkg;

    // ------------------------------------------------------------
    // Clocks and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned PROBE_CLK_NS = 200;
    localparam logic [2:0] PROBE_HALF = 3'(PROBE_CLK_NS / CLK_NS / 2);
    localparam logic [2:0] PROBE_LAST_PHASE = 3'(PROBE_CLK_NS / CLK_NS - 1);
    localparam int unsigned RST_PULSE_NS = 1000;
    localparam logic [5:0] RST_PULSE_CYC = 6'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam int unsigned SLOW_HZ = 32768;
    localparam logic [10:0] SLOW_DIV_LAST = 11'(CLK_HZ / SLOW_HZ - 1);
    localparam int unsigned WIPE_MIN_US = 1000;
    localparam logic [7:0] WIPE_TICKS = 8'((WIPE_MIN_US * SLOW_HZ + 999_999) / 1_000_000);

    // ------------------------------------------------------------
    // Switch sequences
    // ------------------------------------------------------------
    localparam int unsigned SEL_MIN_HIGH = 50;
    localparam logic [5:0] SEL_HIGH_CLKS = 6'(SEL_MIN_HIGH + 1);
    localparam logic [15:0] PAT_TO_SERIAL = 16'h79e7;
    localparam logic [15:0] PAT_TO_SCAN = 16'h3ce7;
    localparam logic [4:0] PAT_LAST_BIT = 5'h0f;

    // ------------------------------------------------------------
    // Synchroniser bit positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned SY_CLK = 0;
    localparam int unsigned SY_MD = 1;
    localparam int unsigned SY_NRST = 2;
    localparam int unsigned SY_TDI = 3;
    localparam int unsigned SY_TEST = 4;
    localparam int unsigned SY_SEL = 5;
    localparam int unsigned SY_PORTA = 6;
    localparam int unsigned SY_WIPE = 7;
    localparam logic [7:0] SY_RESET = 8'h07;
    localparam logic [1:0] WARM_DONE = 2'h3;

    typedef enum logic [1:0] {
        DET_HUNT = 2'b00,
        DET_PAT = 2'b01,
        DET_TAIL = 2'b10
    } dpt_det_type;

    typedef enum logic [1:0] {
        PRB_IDLE = 2'b00,
        PRB_HEAD = 2'b01,
        PRB_PAT = 2'b10,
        PRB_TAIL = 2'b11
    } dpt_prb_type;

endpackage : dpt_pkg

// ### dpt_probe.sv
`timescale 1ns/1ps
module dpt_probe
    import dpt_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    dpt_link_if.probe link,
    input wire logic go_serial_i,
    input wire logic go_scan_i,
    input wire logic reset_req_i,
    input wire logic test_mode_i,
    input wire logic scan_select_i,
    input wire logic port_a_qual_i,
    input wire logic wipe_i,
    input wire logic tdi_i,
    output logic busy_o,
    output logic done_o,
    output logic tdo_o,
    output logic md_o,
    output logic nrst_low_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        dpt_prb_type st;
        logic [2:0] phase;
        logic [5:0] cnt;
        logic [15:0] pat;
        logic clk;
        logic md_out;
        logic md_oe_n;
        logic [5:0] rcnt;
        logic nrst_oe_n;
        logic test;
        logic sel;
        logic porta;
        logic wipe;
        logic tdi;
        logic done;
    } dpt_prb_state_type;

    localparam dpt_prb_state_type PRB_RESET = '{
        s1: 3'h6, s2: 3'h6, st: PRB_IDLE, phase: 3'h0, cnt: 6'h00, pat: 16'h0000,
        clk: 1'b1, md_out: 1'b1, md_oe_n: 1'b1, rcnt: 6'h00, nrst_oe_n: 1'b1,
        test: 1'b0, sel: 1'b0, porta: 1'b0, wipe: 1'b0, tdi: 1'b0, done: 1'b0
    };

    dpt_prb_state_type q;
    dpt_prb_state_type n;

    logic start_reset;

    // A scan_select strap move is useless until the chip is reset, so it forces one
    assign start_reset = reset_req_i | (scan_select_i != q.sel);

    always_comb begin
        n = q;
        n.s1 = {link.nrst, link.mode_data, link.tdo};
        n.s2 = q.s1;
        n.done = 1'b0;
        n.test = test_mode_i;
        n.sel = scan_select_i;
        n.porta = port_a_qual_i;
        n.wipe = wipe_i;
        n.tdi = tdi_i;

        // ------------------------------------------------------------
        // Reset drive
        // ------------------------------------------------------------
        if (start_reset && q.nrst_oe_n) begin
            n.nrst_oe_n = 1'b0; // RQ1 RQ14
            n.rcnt = RST_PULSE_CYC;
        end else if (!q.nrst_oe_n) begin
            n.rcnt = q.rcnt - 6'h01;
            if (q.rcnt == 6'h01) begin
                n.nrst_oe_n = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Switch sequence; data moves on the falling edge
        // ------------------------------------------------------------
        if (q.st == PRB_IDLE) begin
            if (go_serial_i || go_scan_i) begin
                n.st = PRB_HEAD;
                n.phase = 3'h0;
                n.cnt = 6'h00;
                n.md_oe_n = 1'b0;
                n.pat = go_serial_i ? PAT_TO_SERIAL : PAT_TO_SCAN; // RQ16 RQ17
            end
        end else begin
            n.phase = (q.phase == PROBE_LAST_PHASE) ? 3'h0 : q.phase + 3'h1;
            if (q.phase == 3'h0) begin
                n.clk = 1'b0;
                n.md_out = (q.st == PRB_PAT) ? q.pat[15] : 1'b1;
            end else if (q.phase == PROBE_HALF) begin
                n.clk = 1'b1;
                n.cnt = q.cnt + 6'h01;
                case (q.st)
                    PRB_HEAD: begin
                        if (q.cnt == SEL_HIGH_CLKS - 6'h01) begin
                            n.st = PRB_PAT; // RQ16 RQ17
                            n.cnt = 6'h00;
                        end
                    end
                    PRB_PAT: begin
                        n.pat = {q.pat[14:0], 1'b0};
                        if (q.cnt == 6'(PAT_LAST_BIT)) begin
                            n.st = PRB_TAIL;
                            n.cnt = 6'h00;
                        end
                    end
                    PRB_TAIL: begin
                        if (q.cnt == SEL_HIGH_CLKS - 6'h01) begin
                            n.st = PRB_IDLE; // RQ16 RQ17
                            n.md_oe_n = 1'b1;
                            n.done = 1'b1;
                        end
                    end
                    default: begin
                        n.st = PRB_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= PRB_RESET;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.probe_clk = q.clk;
    assign link.md_probe_out = q.md_out;
    assign link.md_probe_oe_n = q.md_oe_n;
    assign link.tdi = q.tdi;
    assign link.nrst_probe_oe_n = q.nrst_oe_n;
    assign link.test_mode = q.test;
    assign link.scan_select = q.sel;
    assign link.port_a_qual = q.porta;
    assign link.wipe_pin = q.wipe;
    assign busy_o = (q.st != PRB_IDLE);
    assign done_o = q.done;
    assign tdo_o = q.s2[0];
    assign md_o = q.s2[1];
    assign nrst_low_o = ~q.s2[2];

endmodule : dpt_probe

// ### tb.sv
`timescale 1ns/1ps
module tb;
    import dpt_pkg::*;
    localparam int LIMIT = 98000;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rst_req = 1'b0, dbg_gpio_sel = 1'b0, wipe_gpio_sel = 1'b0, scan_tdo = 1'b0, trace = 1'b0;
    logic go_serial = 1'b0, go_scan = 1'b0, reset_req = 1'b0, test_mode = 1'b0, scan_select = 1'b0;
    logic port_a_qual = 1'b0, wipe = 1'b0, tdi = 1'b0, gpio_oe = 1'b0, sw_out = 1'b0, sw_oe = 1'b0;
    logic [1:0] gpio_out = 2'h0;
    logic core_reset, periph_reset, flash_wipe, variant_serial, boundary_scan, fast_prog;
    logic done, tdo, nrst_low, tdi_seen, md_seen;
    logic [3:0] gpio_in;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'hdbceed49;
    logic var_q[$];
    logic wipe_q[$];
    logic var_seen = 1'b0;
    logic cur_var = 1'b0;
    logic prev_bs = 1'b0;

    dpt_link_if i_dpt_link_if();
    dpt_device i_dpt_device (.clock_i(clock_i), .resetn_i(resetn_i), .link(i_dpt_link_if), .rst_req_i(rst_req),
        .dbg_gpio_sel_i(dbg_gpio_sel), .wipe_gpio_sel_i(wipe_gpio_sel), .gpio_oe_i(gpio_oe), .gpio_out_i(gpio_out),
        .sw_out_i(sw_out), .sw_oe_i(sw_oe), .scan_tdo_i(scan_tdo), .trace_i(trace), .core_reset_o(core_reset),
        .periph_reset_o(periph_reset), .flash_wipe_o(flash_wipe), .variant_serial_o(variant_serial),
        .boundary_scan_o(boundary_scan), .fast_prog_o(fast_prog), .sw_clk_rise_o(), .scan_clk_rise_o(),
        .md_o(), .tdi_o(tdi_seen), .gpio_in_o(gpio_in));
    dpt_probe i_dpt_probe (.clock_i(clock_i), .resetn_i(resetn_i), .link(i_dpt_link_if), .go_serial_i(go_serial),
        .go_scan_i(go_scan), .reset_req_i(reset_req), .test_mode_i(test_mode), .scan_select_i(scan_select),
        .port_a_qual_i(port_a_qual), .wipe_i(wipe), .tdi_i(tdi), .busy_o(), .done_o(done), .tdo_o(tdo),
        .md_o(md_seen), .nrst_low_o(nrst_low));
    dpt_checker i_dpt_checker (.clock_i(clock_i), .resetn_i(resetn_i), .probe_clk(i_dpt_link_if.probe_clk),
        .md_probe_out(i_dpt_link_if.md_probe_out), .md_probe_oe_n(i_dpt_link_if.md_probe_oe_n),
        .md_dev_oe_n(i_dpt_link_if.md_dev_oe_n), .nrst_dev_oe_n(i_dpt_link_if.nrst_dev_oe_n),
        .nrst_probe_oe_n(i_dpt_link_if.nrst_probe_oe_n), .scan_select(i_dpt_link_if.scan_select));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    // ------
    // Shared tasks
    // ------
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask : step

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude;
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Frozen means GPIO mode or boundary scan; otherwise only the other variant's pattern switches
    task automatic seq(input logic to_serial, input logic frozen);
        int n;
        go_serial = to_serial;
        go_scan = !to_serial;
        if (!frozen && to_serial !== cur_var) begin
            var_q.push_back(to_serial);
            cur_var = to_serial;
        end
        step(1);
        go_serial = 1'b0;
        go_scan = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1200) begin
            step(1);
            n++;
        end
        chk("done", 4'h1, {3'h0, done});
        step(10);
        chk("pending", 4'h0, 4'(var_q.size()));
    endtask : seq

    // Mode 0 scan chain, 1 serial wire, 2 general I/O
    task automatic mux(input int mode);
        logic [7:0] r;
        logic m;
        repeat (3) begin
            r = 8'($random(seed));
            {sw_oe, sw_out, gpio_oe, tdi, gpio_out, scan_tdo, trace} = r;
            m = (mode == 2) ? (!r[5] | r[2]) : ((mode == 1) ? (!r[7] | r[6]) : 1'b1);
            step(8);
            chk("tdo", {3'h0, mode == 2 ? r[3] : (mode == 1 ? r[0] : r[1])}, {3'h0, tdo});
            chk("gpio_in", {r[4], 1'b1, m, 1'b0}, gpio_in);
            chk("tdi", {3'h0, r[4]}, {3'h0, tdi_seen});
            chk("md", {3'h0, m}, {3'h0, md_seen});
        end
    endtask : mux

    task automatic pin_reset(input logic by_device);
        if (cur_var) begin
            var_q.push_back(1'b0);
        end
        cur_var = 1'b0;
        rst_req = by_device;
        reset_req = !by_device;
        step(1);
        rst_req = 1'b0;
        reset_req = 1'b0;
        step(8);
        chk("nrst_low", 4'h1, {3'h0, nrst_low});
        chk("core_reset", 4'h1, {3'h0, core_reset});
        chk("periph_reset", 4'h1, {3'h0, periph_reset});
        step(60);
        chk("nrst_low", 4'h0, {3'h0, nrst_low});
        chk("core_reset", 4'h0, {3'h0, core_reset});
    endtask : pin_reset

    // ------
    // Result monitor
    // ------
    always @(posedge clock_i) begin
        cycles++;
        if (resetn_i && variant_serial !== var_seen) begin
            chk("variant", var_q.size() != 0 ? {3'h0, var_q.pop_front()} : 4'hx, {3'h0, variant_serial});
            var_seen = variant_serial;
        end
        if (resetn_i && flash_wipe === 1'b1) begin
            chk("wipe", wipe_q.size() != 0 ? {3'h0, wipe_q.pop_front()} : 4'hx, {3'h0, flash_wipe});
        end
        if (cycles >= LIMIT) begin
            err_total++;
            conclude();
        end
    end

    // ------
    // Main sequence
    // ------
    initial begin
        step(5);
        resetn_i = 1'b1;
        step(8);
        chk("variant", 4'h0, {3'h0, variant_serial});
        chk("bscan", 4'h0, {3'h0, boundary_scan});
        chk("fastprog", 4'h0, {3'h0, fast_prog});
        chk("nrst_low", 4'h0, {3'h0, nrst_low});
        mux(0);
        seq(1'b1, 1'b0);
        mux(1);
        seq(1'b1, 1'b0);
        seq(1'b0, 1'b0);
        seq(1'b0, 1'b0);
        dbg_gpio_sel = 1'b1;
        step(4);
        mux(2);
        seq(1'b1, 1'b1);
        dbg_gpio_sel = 1'b0;
        step(4);
        seq(1'b1, 1'b0);
        pin_reset(1'b1);
        seq(1'b1, 1'b0);
        pin_reset(1'b0);
        seq(1'b1, 1'b0);
        // A second reset in mid-run returns the port to the scan chain variant
        var_q.push_back(1'b0);
        cur_var = 1'b0;
        resetn_i = 1'b0;
        step(2);
        resetn_i = 1'b1;
        step(8);
        for (int i = 0; i < 8; i++) begin
            test_mode = i[2];
            port_a_qual = i[0];
            if (scan_select !== i[1]) begin
                prev_bs = i[2] & i[1] & !i[0];
            end
            scan_select = i[1];
            step(80);
            chk("bscan_held", {3'h0, prev_bs}, {3'h0, boundary_scan});
            reset_req = 1'b1;
            step(1);
            reset_req = 1'b0;
            step(80);
            prev_bs = i[2] & i[1] & !i[0];
            chk("bscan", {3'h0, prev_bs}, {3'h0, boundary_scan});
            chk("fastprog", {3'h0, i[2] & !prev_bs}, {3'h0, fast_prog});
            if (i == 6) begin
                seq(1'b1, 1'b1);
            end
        end
        test_mode = 1'b0;
        scan_select = 1'b0;
        port_a_qual = 1'b0;
        step(80);
        // Debounce: a short assertion and a pin in GPIO mode must both leave the flash alone
        wipe = 1'b1;
        step(1400);
        wipe = 1'b0;
        wipe_gpio_sel = 1'b1;
        step(10);
        wipe = 1'b1;
        step(40400);
        wipe = 1'b0;
        step(10);
        wipe_gpio_sel = 1'b0;
        wipe_q.push_back(1'b1);
        wipe = 1'b1;
        step(40400);
        wipe = 1'b0;
        step(10);
        chk("wipe_left", 4'h0, 4'(wipe_q.size()));
        conclude();
    end
endmodule : tb
